// >>> verilog/adc_host_read_port.sv
`timescale 1ns/1ps
`default_nettype none
module adc_host_read_port #(
  parameter logic [15:0] TIMER_PERIOD = adc_host_pkg::TIMER_PERIOD_DEFAULT,
  parameter int CONV_CYCLES = adc_host_pkg::CONV_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  // Mode straps
  input wire logic timerStartEn,
  input wire logic useInterrupt,
  input wire logic byteMode,
  // Processor side
  input wire logic startWrite,
  input wire logic readRequest,
  input wire logic host_data_strobe_n,
  input wire logic hostRead,
  input wire logic host_address_strobe_n,
  input wire logic host_memory_select,
  output logic host_transfer_ack_n,
  output logic irqRequest_n,
  output logic [11:0] readData,
  output logic readValid,
  output logic busyOut,
  // Converter side
  input wire logic convDone,
  input wire logic [11:0] result_data_bits,
  output logic conversion_start_n,
  output logic chipSelect_n,
  output logic readStrobe_n
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_CONV = 3'b010,
    ST_READ = 3'b011,
    ST_WAIT = 3'b100,
    ST_READ2 = 3'b101
  } state_e;

  state_e state_reg, state_next;
  logic [15:0] timer_reg, timer_next;
  logic [15:0] cnt_reg, cnt_next;
  logic startN_reg, startN_next;
  logic csN_reg, csN_next;
  logic rdN_reg, rdN_next;
  logic ackN_reg, ackN_next;
  logic [11:0] data_reg, data_next;
  logic [3:0] hold_reg, hold_next;
  logic valid_reg, valid_next;
  logic busy_reg, busy_next;
  logic ready_reg, ready_next;
  logic doneDly_reg;
  logic irqN_reg;
  logic irqN_next;
  logic shotPulse;
  logic doneRise;
  logic timerTick;
  logic cpuStrobe;
  logic startReq;

  // ----------------------------------------
  // Strobe decode and events
  // ----------------------------------------
  assign cpuStrobe = (!host_data_strobe_n || !host_address_strobe_n) && hostRead;
  assign doneRise = convDone && !doneDly_reg;
  assign timerTick = timerStartEn && (timer_reg == 16'h0000);
  assign startReq = timerTick || startWrite;

  one_shot #(.WIDTH_CYCLES(adc_host_pkg::ONESHOT_CYCLES)) u_shot (
    .clk(clk),
    .rst(rst),
    .trigger(doneRise && byteMode),
    .pulse(shotPulse)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    timer_next = (timer_reg == 16'h0000) ? TIMER_PERIOD : timer_reg - 16'h0001;
    cnt_next = cnt_reg;
    startN_next = startN_reg;
    csN_next = csN_reg;
    rdN_next = rdN_reg;
    ackN_next = 1'b1;
    data_next = data_reg;
    hold_next = hold_reg;
    valid_next = 1'b0;
    busy_next = busy_reg;
    ready_next = ready_reg;
    irqN_next = !(useInterrupt && (byteMode ? shotPulse : doneRise));
    case (state_reg)
      ST_IDLE: begin
        if (startReq) begin
          state_next = ST_START;
          startN_next = 1'b0;
          busy_next = 1'b1;
          ready_next = 1'b0;
          cnt_next = 16'(adc_host_pkg::START_CYCLES - 1);
        end else if (ready_reg && (readRequest || cpuStrobe)) begin
          state_next = ST_READ;
          csN_next = 1'b0;
          rdN_next = 1'b0;
          cnt_next = 16'(adc_host_pkg::READ_CYCLES + adc_host_pkg::WAIT_STATES - 1);
        end
      end
      ST_START: begin
        if (cnt_reg == 16'h0000) begin
          startN_next = 1'b1;
          state_next = ST_CONV;
          cnt_next = 16'(CONV_CYCLES - 1);
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      ST_CONV: begin
        if (useInterrupt ? doneRise : (cnt_reg == 16'h0000)) begin
          state_next = ST_IDLE;
          busy_next = 1'b0;
          ready_next = 1'b1;
        end else if (cnt_reg != 16'h0000) begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      ST_READ: begin
        if (cnt_reg == 16'h0000 && !host_memory_select) begin
          csN_next = 1'b1;
          rdN_next = 1'b1;
          ackN_next = 1'b0;
          if (byteMode) begin
            data_next = {4'h0, result_data_bits[7:0]};
            hold_next = result_data_bits[11:8];
            state_next = ST_WAIT;
          end else begin
            data_next = result_data_bits;
            ready_next = 1'b0;
            state_next = ST_IDLE;
          end
          valid_next = 1'b1;
        end else if (cnt_reg != 16'h0000) begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      ST_WAIT: begin
        if (readRequest || cpuStrobe) begin
          state_next = ST_READ2;
        end
      end
      ST_READ2: begin
        data_next = {8'h00, hold_reg};
        valid_next = 1'b1;
        ackN_next = 1'b0;
        ready_next = 1'b0;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      timer_reg <= 16'h0000;
      cnt_reg <= 16'h0000;
      startN_reg <= 1'b1;
      csN_reg <= 1'b1;
      rdN_reg <= 1'b1;
      ackN_reg <= 1'b1;
      data_reg <= 12'h000;
      hold_reg <= 4'h0;
      valid_reg <= 1'b0;
      busy_reg <= 1'b0;
      ready_reg <= 1'b0;
      // Status idles high, so no false edge after reset
      doneDly_reg <= 1'b1;
      irqN_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      cnt_reg <= cnt_next;
      startN_reg <= startN_next;
      csN_reg <= csN_next;
      rdN_reg <= rdN_next;
      ackN_reg <= ackN_next;
      data_reg <= data_next;
      hold_reg <= hold_next;
      valid_reg <= valid_next;
      busy_reg <= busy_next;
      ready_reg <= ready_next;
      doneDly_reg <= convDone;
      irqN_reg <= irqN_next;
    end
  end

  assign conversion_start_n = startN_reg;
  assign chipSelect_n = csN_reg;
  assign readStrobe_n = rdN_reg;
  assign host_transfer_ack_n = ackN_reg;
  assign irqRequest_n = irqN_reg;
  assign readData = data_reg;
  assign readValid = valid_reg;
  assign busyOut = busy_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_no_read_busy: assert property (@(posedge clk) disable iff (rst)
    busy_reg |-> rdN_reg) else $error("read during conversion");
  a_start_pulse: assert property (@(posedge clk) disable iff (rst)
    $fell(startN_reg) |-> !startN_reg [*2]) else $error("start pulse short");
  a_start_from_write: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_IDLE && startWrite) |=> !startN_reg) else $error("write start lost");
  a_read_wait: assert property (@(posedge clk) disable iff (rst)
    $fell(rdN_reg) |-> !rdN_reg [*2]) else $error("no wait state");
  a_ack_on_read: assert property (@(posedge clk) disable iff (rst)
    $rose(csN_reg) |-> !ackN_reg) else $error("ack missing");
  a_low_byte: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_READ && state_next == ST_WAIT) |=>
    readValid && readData[11:8] == 4'h0) else $error("low byte wrong");
  a_high_nibble: assert property (@(posedge clk) disable iff (rst)
    state_reg == ST_READ2 |=> readData == {8'h00, $past(hold_reg)}) else $error("nibble wrong");
  a_irq_on_done: assert property (@(posedge clk) disable iff (rst)
    (doneRise && useInterrupt && !byteMode) |=> !irqRequest_n) else $error("no irq");
  a_cs_with_rd: assert property (@(posedge clk) disable iff (rst)
    csN_reg == rdN_reg) else $error("strobes apart");
endmodule
`default_nettype wire

// >>> verilog/adc_host_pkg.sv
package adc_host_pkg;
  localparam int DATA_WIDTH = 12;
  localparam int LOW_WIDTH = 8;
  localparam int HIGH_WIDTH = 4;
  // Timing figures, ns
  localparam int CLK_PERIOD_NS = 8;
  localparam int CONV_TIME_NS = 12000;
  localparam int START_PULSE_NS = 100;
  localparam int READ_PULSE_NS = 80;
  localparam int ONESHOT_NS = 200;
  // Derived cycle counts
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_CYCLES = (START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYCLES = (READ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ONESHOT_CYCLES = (ONESHOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_STATES = 1;
  localparam int CNT_WIDTH = 16;
  localparam logic [15:0] TIMER_PERIOD_DEFAULT = 16'h0753;
endpackage

// >>> verilog/one_shot.sv
`timescale 1ns/1ps
`default_nettype none
module one_shot #(
  parameter int WIDTH_CYCLES = 25
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic trigger,
  output logic pulse
);
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic pulse_reg;
  logic pulse_next;

  always_comb begin
    count_next = count_reg;
    pulse_next = pulse_reg;
    if (trigger) begin
      count_next = 16'(WIDTH_CYCLES - 1);
      pulse_next = 1'b1;
    end else if (count_reg != 16'h0000) begin
      count_next = count_reg - 16'h0001;
    end else begin
      pulse_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= 16'h0000;
      pulse_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      pulse_reg <= pulse_next;
    end
  end

  assign pulse = pulse_reg;

  a_pulse_width: assert property (@(posedge clk) disable iff (rst)
    $rose(pulse_reg) |-> pulse_reg [*2]) else $error("one-shot pulse too short");
endmodule
`default_nettype wire

// >>> tb/adc_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Converter at the far side
// ------------------------------
module adc_conv_model #(
  parameter int CONV_LAT = 4
) (
  input wire logic clk,
  input wire logic conversion_start_n,
  input wire logic chipSelect_n,
  input wire logic readStrobe_n,
  input wire logic [11:0] sampleIn,
  output logic convDone,
  output logic [11:0] result_data_bits
);
  logic [11:0] held_reg = 12'h000;
  int cnt_reg = 0;
  initial convDone = 1'b1;
  always @(posedge clk) begin
    if (conversion_start_n === 1'b0) begin
      convDone <= 1'b0;
      cnt_reg <= CONV_LAT;
    end else if (cnt_reg > 0) begin
      cnt_reg <= cnt_reg - 1;
      if (cnt_reg == 1) begin
        convDone <= 1'b1;
        held_reg <= sampleIn;
      end
    end
  end
  // Released bus shows the inverse, never a stale copy
  assign result_data_bits = (!chipSelect_n && !readStrobe_n) ? held_reg : ~held_reg;
endmodule
`default_nettype wire

// >>> tb/adc_host_read_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module adc_host_read_port_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic timerStartEn = 1'b0, useInterrupt = 1'b1, byteMode = 1'b0, startWrite = 1'b0;
  logic readRequest = 1'b0, hostRead = 1'b0, host_memory_select = 1'b0;
  logic host_data_strobe_n = 1'b1, host_address_strobe_n = 1'b1;
  logic host_transfer_ack_n, irqRequest_n, readValid, busyOut, convDone;
  logic conversion_start_n, chipSelect_n, readStrobe_n;
  logic [11:0] readData, result_data_bits, sample = 12'h000;
  int n_mismatch = 0, checked = 0, badRd = 0;
  always #4 clk = ~clk;
  adc_host_read_port #(.TIMER_PERIOD(16'h0031), .CONV_CYCLES(40)) i_adc_host_read_port (
    .clk(clk), .rst(rst), .timerStartEn(timerStartEn), .useInterrupt(useInterrupt),
    .byteMode(byteMode), .startWrite(startWrite), .readRequest(readRequest),
    .host_data_strobe_n(host_data_strobe_n), .hostRead(hostRead),
    .host_address_strobe_n(host_address_strobe_n), .host_memory_select(host_memory_select),
    .host_transfer_ack_n(host_transfer_ack_n), .irqRequest_n(irqRequest_n),
    .readData(readData), .readValid(readValid), .busyOut(busyOut), .convDone(convDone),
    .result_data_bits(result_data_bits), .conversion_start_n(conversion_start_n),
    .chipSelect_n(chipSelect_n), .readStrobe_n(readStrobe_n));
  adc_conv_model #(.CONV_LAT(4)) i_adc_conv_model (.clk(clk),
    .conversion_start_n(conversion_start_n), .chipSelect_n(chipSelect_n),
    .readStrobe_n(readStrobe_n), .sampleIn(sample), .convDone(convDone),
    .result_data_bits(result_data_bits));
  always @(posedge clk) if (chipSelect_n === 1'b0 && convDone !== 1'b1) badRd++;
  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic conv(input logic [11:0] s);
    int k;
    int stN;
    int irN;
    int vN;
    stN = 0;
    irN = 0;
    vN = 0;
    sample <= s;
    startWrite <= 1'b1;
    for (k = 0; k < 300; k++) begin
      @(posedge clk);
      startWrite <= 1'b0;
      readRequest <= (k == 3);
      if (conversion_start_n === 1'b0) stN++;
      if (irqRequest_n === 1'b0) irN++;
      if (readValid === 1'b1) vN++;
      if (k > 3 && busyOut === 1'b0 && (!useInterrupt || (irN > 0 && irqRequest_n === 1'b1)))
        break;
    end
    chk(12'(stN), 12'(adc_host_pkg::START_CYCLES));
    chk(12'(vN), 12'h000);
    if (useInterrupt) chk(12'(irN), byteMode ? 12'h019 : 12'h001);
  endtask
  task automatic rd(input int how, input logic msel, input logic [11:0] exp, input int expCs);
    int k;
    int csLow;
    csLow = 0;
    @(posedge clk);
    readRequest <= (how == 0);
    hostRead <= 1'b1;
    host_data_strobe_n <= (how != 1);
    host_address_strobe_n <= (how != 2);
    host_memory_select <= msel;
    for (k = 0; k < 300; k++) begin
      @(posedge clk);
      readRequest <= 1'b0;
      if (k == 15) host_memory_select <= 1'b0;
      if (chipSelect_n === 1'b0) csLow++;
      if (readValid === 1'b1) break;
    end
    host_data_strobe_n <= 1'b1;
    host_address_strobe_n <= 1'b1;
    hostRead <= 1'b0;
    chk(12'(host_transfer_ack_n), 12'h000);
    chk(readData, exp);
    if (msel) chk(12'(csLow > 11), 12'h001);
    else chk(12'(csLow), 12'(expCs));
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_modes;
    conv(12'hC35);
    rd(0, 1'b0, 12'hC35, 11);
    useInterrupt <= 1'b0;
    conv(12'h3CA);
    rd(1, 1'b0, 12'h3CA, 11);
    conv(12'h5A0);
    rd(2, 1'b0, 12'h5A0, 11);
    useInterrupt <= 1'b1;
    conv(12'hFFF);
    rd(0, 1'b1, 12'hFFF, 0);
    $display("test word_modes done");
  endtask
  task automatic t_byte;
    byteMode <= 1'b1;
    conv(12'hA5C);
    rd(0, 1'b0, 12'h05C, 11);
    rd(0, 1'b0, 12'h00A, 0);
    byteMode <= 1'b0;
    $display("test byte_split done");
  endtask
  task automatic t_timer;
    int k;
    int f1;
    int nF;
    logic prev;
    prev = 1'b1;
    nF = 0;
    f1 = 0;
    timerStartEn <= 1'b1;
    for (k = 0; k < 400 && nF < 2; k++) begin
      @(posedge clk);
      if (prev === 1'b1 && conversion_start_n === 1'b0) begin
        if (nF == 1) chk(12'(k - f1), 12'h032);
        f1 = k;
        nF++;
      end
      prev = conversion_start_n;
    end
    timerStartEn <= 1'b0;
    chk(12'(nF), 12'h002);
    $display("test timer_start done");
  endtask
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_modes;
    t_byte;
    t_timer;
    chk(12'(badRd), 12'h000);
    end_sim;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    end_sim;
  end
endmodule
`default_nettype wire
